// file: src/bml_loader.sv
// Boot mode loader: strap decode, EPROM bootstrap DMA on channel six, boot select and packing override.
// Assumes all inputs are synchronous to clk; host and link download sequencing live elsewhere.
`timescale 1ns/1ps
module bml_loader (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                rst_b,
	// Boot straps
	input  wire logic                eprom_boot_strap,
	input  wire logic                link_boot_strap,
	// Boot memory select pin, active low
	input  wire logic                boot_mem_select_i,
	output logic                     boot_mem_select_o,
	output logic                     boot_mem_select_oe,
	// Acknowledge pin
	input  wire logic                ack_i,
	output logic                     ack_o,
	output logic                     ack_oe,
	// External bus
	input  wire logic                bus_master,
	output logic [31:0]              ext_addr,
	output logic                     ext_rd_b,
	input  wire logic [31:0]         ext_data_in,
	output logic                     mem_sel_en,
	// Unbanked wait settings written by software
	input  wire logic                wait_wr,
	input  wire logic [2:0]          wait_count_wr,
	input  wire logic [1:0]          wait_mode_wr,
	// Post-boot DMA through the override
	input  wire logic                boot_select_override,
	input  wire bml_pkg::bml_xfer_t  xfer,
	input  wire logic [1:0]          packing_field,
	output logic [1:0]               packing_eff,
	output logic                     illegal_ch6_write,
	// Internal memory write port
	output logic                     imem_valid,
	input  wire logic                imem_ready,
	output bml_pkg::bml_word_t       imem_word,
	// Core status
	output bml_pkg::bml_mode_t       boot_mode,
	output logic [31:0]              pc,
	output logic                     core_run,
	output logic                     ch6_dma_done_irq,
	output logic [15:0]              ch6_dma_control,
	output logic [15:0]              ch6_external_count,
	output logic [15:0]              ch6_internal_count
);
	typedef enum logic [2:0] {S_SAMPLE, S_SETUP, S_ARB, S_READ, S_DRAIN, S_WAKE, S_IDLE, S_RUN} bml_state_t;

	bml_state_t         st_q, st_d;
	bml_pkg::bml_mode_t mode_q, mode_d;
	logic [31:0]        pc_q, pc_d;
	logic [31:0]        ei_q, ei_d, ii_q, ii_d;
	logic [15:0]        ec_q, ec_d, ic_q, ic_d, ctl_q, ctl_d;
	logic [2:0]         wcnt_q, wcnt_d, wait_count_q, wait_count_d;
	logic [1:0]         wait_mode_q, wait_mode_d;
	logic               boot_q, boot_d, irq_q, irq_d;
	logic               acc_done, byte_ready, word_valid, word_ready;
	logic               ovr_sel, boot_sel;
	logic [bml_pkg::WORD_W-1:0] word_data;
	bml_pkg::bml_word_t skid_in, skid_out;

	// The keeper holds acknowledge high while reset is low, so no pull-up is needed.
	assign ack_o  = 1'b1;
	assign ack_oe = !rst_b;

	// An access ends after the wait states and, in the combined mode, only with acknowledge high.
	assign acc_done = (st_q == S_READ) && (wcnt_q == 3'h0)
		&& (wait_mode_q == bml_pkg::WAIT_MODE_INT || ack_i);

	// Core accesses never reach xfer, so the override can only fire for DMA.
	assign ovr_sel  = boot_select_override && xfer.active && !boot_q;
	assign boot_sel = (boot_q && bus_master) || ovr_sel;

	always_comb begin
		boot_mem_select_o  = !boot_sel;
		boot_mem_select_oe = (mode_q == bml_pkg::MODE_EPROM) && (bus_master || ovr_sel);
		mem_sel_en         = !boot_q && !ovr_sel;
		ext_addr           = ei_q;
		ext_rd_b           = (st_q != S_READ);
		illegal_ch6_write  = boot_select_override && xfer.active && xfer.write
			&& xfer.chan == bml_pkg::CHAN_6;
		packing_eff        = packing_field;
		if (boot_q) begin
			packing_eff = bml_pkg::PACK_8_48;
		end else if (boot_select_override && xfer.active) begin
			if (!xfer.write && xfer.chan == bml_pkg::CHAN_6) begin
				packing_eff = bml_pkg::PACK_8_48;
			end else if (xfer.write && xfer.chan != bml_pkg::CHAN_6) begin
				packing_eff = bml_pkg::PACK_16_48;
			end
		end
	end

	// Bytes come from the upper middle lane of the data bus.
	bml_packer #(
		.BW (bml_pkg::BYTE_W),
		.N  (bml_pkg::BYTES_PER_WORD)
	) u_packer (
		.clk       (clk),
		.rst_b     (rst_b),
		.in_valid  (acc_done),
		.in_ready  (byte_ready),
		.in_data   (ext_data_in[bml_pkg::BYTE_LSB +: bml_pkg::BYTE_W]),
		.out_valid (word_valid),
		.out_ready (word_ready),
		.out_data  (word_data)
	);

	assign skid_in.addr = ii_q;
	assign skid_in.data = word_data;

	// The buffer lets memory stall without losing a word; the stall reaches the EPROM reads.
	bml_skid #(
		.W ($bits(bml_pkg::bml_word_t))
	) u_skid (
		.clk       (clk),
		.rst_b     (rst_b),
		.in_valid  (word_valid),
		.in_ready  (word_ready),
		.in_data   (skid_in),
		.out_valid (imem_valid),
		.out_ready (imem_ready),
		.out_data  (skid_out)
	);
	assign imem_word = skid_out;

	always_comb begin
		st_d         = st_q;
		mode_d       = mode_q;
		pc_d         = pc_q;
		ei_d         = ei_q;
		ii_d         = ii_q;
		ec_d         = ec_q;
		ic_d         = ic_q;
		ctl_d        = ctl_q;
		wcnt_d       = wcnt_q;
		wait_count_d = wait_count_q;
		wait_mode_d  = wait_mode_q;
		boot_d       = boot_q;
		irq_d        = 1'b0;
		if (wait_wr) begin
			wait_count_d = wait_count_wr;
			wait_mode_d  = wait_mode_wr;
		end
		if (word_valid && word_ready) begin
			ii_d = ii_q + 32'h1;
			ic_d = ic_q - 16'h1;
		end
		unique case (st_q)
			S_SAMPLE: begin
				// Straps are caught once, on the first edge after release.
				if (eprom_boot_strap && link_boot_strap) begin
					mode_d = bml_pkg::MODE_RSVD;
				end else if (eprom_boot_strap) begin
					mode_d = bml_pkg::MODE_EPROM;
				end else begin
					unique case ({link_boot_strap, boot_mem_select_i})
						2'b01:   mode_d = bml_pkg::MODE_HOST;
						2'b11:   mode_d = bml_pkg::MODE_LINK;
						2'b00:   mode_d = bml_pkg::MODE_NONE;
						default: mode_d = bml_pkg::MODE_RSVD;
					endcase
				end
				st_d = S_SETUP;
			end
			S_SETUP: begin
				ii_d = bml_pkg::INT_BOOT_START;
				ic_d = bml_pkg::INT_COUNT_RST;
				ei_d = bml_pkg::EXT_BOOT_START;
				ec_d = bml_pkg::EXT_COUNT_RST;
				unique case (mode_q)
					bml_pkg::MODE_EPROM: begin
						ctl_d  = bml_pkg::CH6_CTL_EPROM;
						boot_d = 1'b1;
						st_d   = S_ARB;
					end
					bml_pkg::MODE_NONE: begin
						pc_d = bml_pkg::NOBOOT_PC;
						st_d = S_RUN;
					end
					bml_pkg::MODE_LINK: begin
						ctl_d = bml_pkg::CH6_CTL_LINK;
						st_d  = S_IDLE;
					end
					bml_pkg::MODE_HOST: begin
						ctl_d = bml_pkg::CH6_CTL_HOST;
						st_d  = S_IDLE;
					end
					default: st_d = S_IDLE;
				endcase
			end
			S_ARB: begin
				if (ec_q == 16'h0) begin
					st_d = S_DRAIN;
				end else if (bus_master && byte_ready) begin
					wcnt_d = wait_count_q;
					st_d   = S_READ;
				end
			end
			S_READ: begin
				if (acc_done) begin
					ei_d = ei_q + 32'h1;
					ec_d = ec_q - 16'h1;
					st_d = S_ARB;
				end else if (wcnt_q != 3'h0) begin
					wcnt_d = wcnt_q - 3'h1;
				end
			end
			S_DRAIN: begin
				// Execution waits until the last word has really reached memory.
				if (ic_q == 16'h0 && !imem_valid && !word_valid) begin
					boot_d = 1'b0;
					irq_d  = 1'b1;
					st_d   = S_WAKE;
				end
			end
			S_WAKE: begin
				pc_d = bml_pkg::DONE_VECTOR;
				st_d = S_RUN;
			end
			S_IDLE: st_d = S_IDLE;
			S_RUN:  st_d = S_RUN;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q         <= S_SAMPLE;
			mode_q       <= bml_pkg::MODE_NONE;
			pc_q         <= bml_pkg::RESET_PC;
			ei_q         <= bml_pkg::EXT_BOOT_START;
			ii_q         <= bml_pkg::INT_BOOT_START;
			ec_q         <= bml_pkg::EXT_COUNT_RST;
			ic_q         <= bml_pkg::INT_COUNT_RST;
			ctl_q        <= bml_pkg::CH6_CTL_RST;
			wcnt_q       <= 3'h0;
			wait_count_q <= bml_pkg::WAIT_COUNT_RST;
			wait_mode_q  <= bml_pkg::WAIT_MODE_RST;
			boot_q       <= 1'b0;
			irq_q        <= 1'b0;
		end else begin
			st_q         <= st_d;
			mode_q       <= mode_d;
			pc_q         <= pc_d;
			ei_q         <= ei_d;
			ii_q         <= ii_d;
			ec_q         <= ec_d;
			ic_q         <= ic_d;
			ctl_q        <= ctl_d;
			wcnt_q       <= wcnt_d;
			wait_count_q <= wait_count_d;
			wait_mode_q  <= wait_mode_d;
			boot_q       <= boot_d;
			irq_q        <= irq_d;
		end
	end

	assign boot_mode          = mode_q;
	assign pc                 = pc_q;
	assign core_run           = (st_q == S_RUN);
	assign ch6_dma_done_irq   = irq_q;
	assign ch6_dma_control    = ctl_q;
	assign ch6_external_count = ec_q;
	assign ch6_internal_count = ic_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence seq_read_start;
		$fell(ext_rd_b) && wait_count_q == 3'h6 && wait_mode_q == bml_pkg::WAIT_MODE_INT;
	endsequence
	sequence seq_read_body;
		!ext_rd_b [*7] ##1 ext_rd_b;
	endsequence

	a_bms_needs_master: assert property (boot_q && !ovr_sel && !bus_master
		|-> boot_mem_select_o && !boot_mem_select_oe)
		else $error("boot select driven while not bus master");
	a_read_seven_cycles: assert property (seq_read_start |-> seq_read_body)
		else $error("boot read strobe not seven cycles");
	a_ack_holds_off: assert property (!ext_rd_b && wait_mode_q == bml_pkg::WAIT_MODE_BOTH && !ack_i
		|=> !ext_rd_b && $stable(ext_addr))
		else $error("access completed with acknowledge low");
	a_count_per_byte: assert property (acc_done
		|=> ec_q == $past(ec_q) - 16'h1 && ext_addr == $past(ext_addr) + 32'h1)
		else $error("external count or address did not step");
	a_wake_vector: assert property ($rose(ch6_dma_done_irq) |-> mem_sel_en ##1
		(pc == bml_pkg::DONE_VECTOR && core_run && !ch6_dma_done_irq))
		else $error("wake sequence did not vector");
	a_boot_no_selects: assert property (boot_q |-> !mem_sel_en && packing_eff == bml_pkg::PACK_8_48)
		else $error("normal selects or packing wrong during boot");
	a_eprom_control: assert property (mode_q == bml_pkg::MODE_EPROM && st_q != S_SETUP && st_q != S_SAMPLE
		|-> ch6_dma_control == bml_pkg::CH6_CTL_EPROM)
		else $error("channel six control not set for boot");
	a_noboot_start: assert property (core_run && mode_q == bml_pkg::MODE_NONE |-> pc == bml_pkg::NOBOOT_PC)
		else $error("no-boot start address wrong");
	a_ovr_write_pack: assert property (!boot_q && boot_select_override && xfer.active && xfer.write
		&& xfer.chan != bml_pkg::CHAN_6 |-> packing_eff == bml_pkg::PACK_16_48 && !boot_mem_select_o)
		else $error("override write packing or select wrong");
	a_done_count: assert property ($rose(ch6_dma_done_irq) |-> ch6_internal_count == 16'h0
		&& ch6_external_count == 16'h0)
		else $error("boot ended before 256 words");
endmodule // bml_loader

// file: src/bml_pkg.sv
// Constants, types and carriers shared by the boot mode loader and its helpers.
// Assumes a single 200 MHz clock and an active-low asynchronous reset in every user.
// Notes on behaviour
// - Strap for EPROM boot high with link strap low selects byte-wide EPROM boot; boot select pin becomes chip select.
// - Otherwise link strap and select input choose host, link or no boot; rest reserved.
// - No-boot mode skips download and starts fetching at external address 0x0040_0004.
// - Boot chip select is driven only while this device is bus master or an override DMA transfer is active.
// - Boot data is packed into 48-bit words and moved through DMA channel six.
// - Exactly 256 words land at internal 0x20000 to 0x200ff before execution starts.
// - Each boot byte is taken from external data bits 23 to 16.
// - During reset the acknowledge line is held high by an internal keeper.
// - In EPROM boot the channel six control register comes up holding 0x02a1.
// - During EPROM boot packing field is ignored; 8-to-48 packing, low byte first.
// - Unbanked wait count resets to six wait states and governs boot select accesses.
// - Reset wait mode needs internal waits and acknowledge; acknowledge low stalls the access.
// - Channel six counts and indexes reset to 256 words, 0x600 bytes and start addresses.
// - After reset, enter idle at the reset address, set up channel six, start reads.
// - Boot reads start at 0x0040_0000, increment each access, strobe with six waits.
// - Normal memory selects stay off during boot; external count drops once per byte.
// - At external count zero stop, raise done interrupt, release select, vector.
// - With override set, DMA transfers assert boot select; core accesses never do.
// - With override, channel six reads force 8-to-48; channel six writes are illegal.
// - With override, writes on channels seven to nine force 16-to-48 packing.
package bml_pkg;
	localparam logic [31:0] EXT_BOOT_START = 32'h0040_0000;
	localparam logic [31:0] NOBOOT_PC      = 32'h0040_0004;
	localparam logic [31:0] RESET_PC       = 32'h0002_0004;
	localparam logic [31:0] DONE_VECTOR    = 32'h0002_0040;
	localparam logic [31:0] INT_BOOT_START = 32'h0002_0000;
	localparam logic [15:0] CH6_CTL_EPROM  = 16'h02a1;
	localparam logic [15:0] CH6_CTL_LINK   = 16'h00a0;
	localparam logic [15:0] CH6_CTL_HOST   = 16'h00a1;
	localparam logic [15:0] CH6_CTL_RST    = 16'h0000;
	localparam logic [15:0] INT_COUNT_RST  = 16'h0100;
	localparam logic [15:0] EXT_COUNT_RST  = 16'h0600;
	localparam int          BYTE_W         = 8;
	localparam int          BYTES_PER_WORD = 6;
	localparam int          WORD_W         = 48;
	localparam int          BYTE_LSB       = 16;
	localparam logic [2:0]  WAIT_COUNT_RST = 3'h6;
	localparam logic [1:0]  WAIT_MODE_BOTH = 2'h0;
	localparam logic [1:0]  WAIT_MODE_INT  = 2'h1;
	localparam logic [1:0]  WAIT_MODE_RST  = 2'h0;
	localparam logic [1:0]  PACK_8_48      = 2'h3;
	localparam logic [1:0]  PACK_16_48     = 2'h1;
	localparam logic [1:0]  CHAN_6         = 2'h0;

	typedef enum logic [2:0] {MODE_NONE, MODE_HOST, MODE_LINK, MODE_EPROM, MODE_RSVD} bml_mode_t;

	typedef struct packed {
		logic [31:0]       addr;
		logic [WORD_W-1:0] data;
	} bml_word_t;

	typedef struct packed {
		logic       active;
		logic [1:0] chan;
		logic       write;
	} bml_xfer_t;
endpackage

// file: src/bml_packer.sv
// Byte-to-word packer: collects bytes low byte first into one wide word.
// Assumes the drain side may stall; the packer then refuses further bytes.
`timescale 1ns/1ps
module bml_packer #(
	parameter int BW = 8,
	parameter int N  = 6
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst_b,
	// Byte side
	input  wire logic              in_valid,
	output logic                   in_ready,
	input  wire logic [BW-1:0]     in_data,
	// Word side
	output logic                   out_valid,
	input  wire logic              out_ready,
	output logic [BW*N-1:0]        out_data
);
	localparam int CW = $clog2(N);

	logic [BW*N-1:0] data_q, data_d;
	logic [CW-1:0]   cnt_q, cnt_d;
	logic            full_q, full_d;

	assign in_ready  = !full_q;
	assign out_valid = full_q;
	assign out_data  = data_q;

	always_comb begin
		data_d = data_q;
		cnt_d  = cnt_q;
		full_d = full_q;
		if (out_valid && out_ready) begin
			full_d = 1'b0;
		end
		if (in_valid && in_ready) begin
			data_d[cnt_q*BW +: BW] = in_data;
			if (cnt_q == CW'(N-1)) begin
				cnt_d  = '0;
				full_d = 1'b1;
			end else begin
				cnt_d = cnt_q + 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			data_q <= '0;
			cnt_q  <= '0;
			full_q <= 1'b0;
		end else begin
			data_q <= data_d;
			cnt_q  <= cnt_d;
			full_q <= full_d;
		end
	end

	a_pack_word_full: assert property (@(posedge clk) disable iff (!rst_b)
		(in_valid && in_ready && cnt_q == CW'(N-1)) |=> (out_valid && out_data[BW*N-1 -: BW] == $past(in_data)))
		else $error("last byte did not complete a word");
endmodule // bml_packer

// file: src/bml_skid.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes the receiver may stall at any time; no word is lost or repeated.
`timescale 1ns/1ps
module bml_skid #(
	parameter int W = 80
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_b,
	// Fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	logic [W-1:0] mem_q [2];
	logic [W-1:0] mem_d [2];
	logic         wp_q, wp_d, rp_q, rp_d;
	logic [1:0]   cnt_q, cnt_d;
	logic         push, pop;

	assign in_ready  = (cnt_q != 2'h2);
	assign out_valid = (cnt_q != 2'h0);
	assign out_data  = mem_q[rp_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		mem_d = mem_q;
		wp_d  = wp_q;
		rp_d  = rp_q;
		cnt_d = cnt_q;
		if (push) begin
			mem_d[wp_q] = in_data;
			wp_d        = !wp_q;
		end
		if (pop) begin
			rp_d = !rp_q;
		end
		if (push && !pop) begin
			cnt_d = cnt_q + 2'h1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 2'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mem_q[0] <= '0;
			mem_q[1] <= '0;
			wp_q     <= 1'b0;
			rp_q     <= 1'b0;
			cnt_q    <= 2'h0;
		end else begin
			mem_q <= mem_d;
			wp_q  <= wp_d;
			rp_q  <= rp_d;
			cnt_q <= cnt_d;
		end
	end
endmodule // bml_skid

// file: verif/bml_eprom_model.sv
// Byte-wide boot EPROM answering on data bits 23:16 under boot select and read strobe.
// Assumes the pin levels resolved by the bench; the other data bits carry noise.
`timescale 1ns/1ps
module bml_eprom_model (
	// Clock for the noise pattern
	input  wire logic        clk,
	// Memory pins; select and read strobe active low
	input  wire logic        cs_b,
	input  wire logic        rd_b,
	input  wire logic [31:0] addr,
	output logic [31:0]      data
);
	logic [7:0] last_q = 8'h00;
	logic [7:0] noise_q = 8'h5c;
	logic       sel;

	assign sel = !cs_b && !rd_b;
	// A released bus shows the inverse of the last byte, so a late sample cannot match by luck.
	always_ff @(posedge clk) begin
		noise_q <= noise_q + 8'h3b;
		if (sel) begin
			last_q <= data[23:16];
		end
	end
	always_comb begin
		data = {~noise_q, 8'h00, noise_q, ~noise_q};
		data[23:16] = sel ? addr[7:0] ^ (addr[15:8] * 8'h1d) ^ 8'ha5 : ~last_q;
	end
endmodule // bml_eprom_model

// file: verif/boot_mode_loader_tb.sv
// Self-checking bench: strap decode, EPROM bootstrap with stalls, override muxing.
// Assumes bml_eprom_model on the external bus and a 200 MHz clock.
`timescale 1ns/1ps
module boot_mode_loader_tb;
	logic               clk, rst_b, e_strap, l_strap, bms_strap, bms_wire, bms_o, bms_oe;
	logic               ack_drv, ack_wire, ack_o, ack_oe, bus_master, ext_rd_b, mem_sel_en;
	logic               wait_wr, override, illegal, imem_valid, imem_ready, core_run, irq;
	logic               ack_prev, int_mode, start_int, booting, ack_rand, hold_ready, hit;
	logic [1:0]         pfield, peff;
	logic [31:0]        ext_addr, ext_data, pc;
	logic [15:0]        ctl, ext_cnt, int_cnt;
	bml_pkg::bml_xfer_t xfer;
	bml_pkg::bml_word_t imem_word;
	bml_pkg::bml_mode_t boot_mode;
	int                 fails, samples_checked, nreads, nwords, low_cnt;
	logic [2:0]         straps [6] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h6, 3'h4};
	bml_pkg::bml_mode_t modes [6] = '{bml_pkg::MODE_NONE, bml_pkg::MODE_HOST, bml_pkg::MODE_LINK,
		bml_pkg::MODE_RSVD, bml_pkg::MODE_RSVD, bml_pkg::MODE_EPROM};

	assign bms_wire = bms_oe ? bms_o : bms_strap;
	assign ack_wire = ack_oe ? ack_o : ack_drv;

	bml_loader dut (.clk(clk), .rst_b(rst_b), .eprom_boot_strap(e_strap), .link_boot_strap(l_strap),
		.boot_mem_select_i(bms_wire), .boot_mem_select_o(bms_o), .boot_mem_select_oe(bms_oe),
		.ack_i(ack_wire), .ack_o(ack_o), .ack_oe(ack_oe), .bus_master(bus_master), .ext_addr(ext_addr),
		.ext_rd_b(ext_rd_b), .ext_data_in(ext_data), .mem_sel_en(mem_sel_en), .wait_wr(wait_wr),
		.wait_count_wr(bml_pkg::WAIT_COUNT_RST), .wait_mode_wr(bml_pkg::WAIT_MODE_INT),
		.boot_select_override(override), .xfer(xfer), .packing_field(pfield), .packing_eff(peff),
		.illegal_ch6_write(illegal), .imem_valid(imem_valid), .imem_ready(imem_ready),
		.imem_word(imem_word), .boot_mode(boot_mode), .pc(pc), .core_run(core_run),
		.ch6_dma_done_irq(irq), .ch6_dma_control(ctl), .ch6_external_count(ext_cnt),
		.ch6_internal_count(int_cnt));

	bml_eprom_model u_rom (.clk(clk), .cs_b(bms_wire), .rd_b(ext_rd_b), .addr(ext_addr), .data(ext_data));

	task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	function automatic logic [47:0] exp_word(input int w);
		logic [47:0] r;
		logic [31:0] a;
		for (int k = 0; k < 6; k++) begin
			a = bml_pkg::EXT_BOOT_START + 32'(6 * w + k);
			r[8*k+:8] = a[7:0] ^ (a[15:8] * 8'h1d) ^ 8'ha5;
		end
		return r;
	endfunction

	function automatic logic [2:0] exp_pack(input logic h, input bml_pkg::bml_xfer_t x, input logic [1:0] pf);
		logic six;
		six = h && (x.chan == bml_pkg::CHAN_6);
		return {six && x.write, six ? (x.write ? 2'h0 : bml_pkg::PACK_8_48) :
			((h && x.write) ? bml_pkg::PACK_16_48 : pf)};
	endfunction

	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic reset_to(input logic [2:0] s);
		rst_b = 1'b0;
		{e_strap, l_strap, bms_strap} = s;
		repeat (20) @(posedge clk);
		#1;
		check("rst_pc", bml_pkg::RESET_PC, pc);
		check("rst_keeper", 2'h3, {ack_oe, ack_wire});
		check("rst_counts", {bml_pkg::EXT_COUNT_RST, bml_pkg::INT_COUNT_RST}, {ext_cnt, int_cnt});
		rst_b = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		{e_strap, l_strap, bms_strap} = 3'($urandom_range(7));
		repeat (3) @(posedge clk);
		#1;
	endtask

	task automatic wait_words(input int n);
		for (int c = 0; c < 30000 && nwords < n; c++) begin
			@(posedge clk);
		end
	endtask

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Random ack, ready and packing field come from this process; the main block only gives them their starting values.
	always @(posedge clk) begin
		#1;
		ack_drv = rst_b ? (ack_rand ? ($urandom_range(3) != 0) : 1'b1) : 1'b0;
		imem_ready = hold_ready ? 1'b0 : ($urandom_range(1) == 1);
		pfield = 2'($urandom_range(3));
	end

	always @(posedge clk) begin
		if (booting) begin
			check("select_oe", {bus_master, 1'b0}, {bms_oe, bms_oe ? bms_o : 1'b0});
			check("mem_sel_off", 1'b0, mem_sel_en);
		end
		if (ext_rd_b === 1'b0) begin
			if (low_cnt == 0) begin
				check("rd_addr", bml_pkg::EXT_BOOT_START + nreads, ext_addr);
				start_int = int_mode;
			end
			low_cnt++;
		end else if (low_cnt > 0) begin
			nreads++;
			if (start_int) begin
				check("strobe_len", 7, low_cnt);
			end else begin
				check("strobe_ack", 2'h3, {low_cnt >= 7, ack_prev});
			end
			check("ext_count", 16'h0600 - nreads, ext_cnt);
			low_cnt = 0;
		end
		ack_prev = ack_wire;
		if (imem_valid === 1'b1 && imem_ready === 1'b1) begin
			check("word_addr", bml_pkg::INT_BOOT_START + nwords, imem_word.addr);
			check("word_data", exp_word(nwords), imem_word.data);
			nwords++;
		end
		if (irq === 1'b1) begin
			check("irq_counts", {16'h0100, 16'h0600}, {16'(nwords), 16'(nreads)});
		end
	end

	initial begin
		#400000;
		fails++;
		$display("MISMATCH watchdog expected done seen timeout");
		end_sim();
	end

	initial begin
		logic [15:0] cnt_mark;
		{rst_b, e_strap, l_strap, bms_strap, ack_drv, bus_master, wait_wr, override} = '0;
		{int_mode, start_int, booting, ack_rand, hold_ready, ack_prev, imem_ready} = '0;
		{xfer, pfield} = '0;
		{fails, samples_checked, nreads, nwords, low_cnt} = '0;
		void'($urandom(33026));
		for (int i = 0; i < 6; i++) begin
			reset_to(straps[i]);
			check("mode", modes[i], boot_mode);
			check("run", {i == 0 ? bml_pkg::NOBOOT_PC : bml_pkg::RESET_PC, i == 0}, {pc, core_run});
		end
		booting = 1'b1;
		check("ctl_eprom", {bml_pkg::CH6_CTL_EPROM, 1'b0}, {ctl, ack_oe});
		for (int c = 0; c < 30; c++) begin
			@(posedge clk);
			#1;
			check("no_master_read", 1'b1, ext_rd_b);
		end
		bus_master = 1'b1;
		@(posedge clk);
		ack_rand <= 1'b1;
		wait_words(100);
		ack_rand <= 1'b0;
		repeat (20) @(posedge clk);
		#1;
		wait_wr = 1'b1;
		@(posedge clk);
		#1;
		wait_wr = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		int_mode = 1'b1;
		repeat (20) @(posedge clk);
		ack_rand <= 1'b1;
		wait_words(150);
		hold_ready <= 1'b1;
		repeat (200) @(posedge clk);
		#1;
		cnt_mark = ext_cnt;
		repeat (50) @(posedge clk);
		#1;
		check("stall_holds", {cnt_mark, 2'h3}, {ext_cnt, ext_rd_b, imem_valid});
		@(posedge clk);
		hold_ready <= 1'b0;
		for (int n = 0; n < 40000 && irq !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		booting = 1'b0;
		// The pin stays driven, but deasserted, while this device still owns the bus.
		check("done_pins", {3'h7, bus_master}, {irq, mem_sel_en, bms_o, bms_oe});
		@(posedge clk);
		#1;
		check("vector", {bml_pkg::DONE_VECTOR, 2'h2}, {pc, core_run, irq});
		for (int i = 0; i < 64; i++) begin
			@(posedge clk);
			#1;
			{bus_master, override, xfer} = 6'(i);
			hit = override && xfer.active;
			#1;
			check("ovr_pins", {bus_master || hit, !hit, !hit}, {bms_oe, mem_sel_en, bms_o});
			check("ovr_pack", exp_pack(hit, xfer, pfield), {illegal, illegal ? 2'h0 : peff});
		end
		end_sim();
	end
endmodule // boot_mode_loader_tb
